// ---- rtl/sars_status.sv ----
`timescale 1ns/1ps
`include "sars_defines.svh"
// Operation
// - target phase change in reselection message-in: stop, report 32H/01H
// - lost arbitration then reselected: report 64H/00H, then the reselection report 90H/00H after acknowledge
// - host command after reselection ran: 64H/00H follows that operation's result
// - extended message of 33+ bytes: take two bytes, report 67H/01H
// - reselection nexus then bus free before any transfer: report 70H/00H
// - reselected by target: report 90H/00H, even with auto mode off
// - message-in with receive buffer occupied: take nothing, report 94H/00H
// - target enters non message-in phase after reselection: report B0H/01H
// - one message received in reselection message-in: report B1H/02H
// - in reselection message-in: reset, parity, timeout, bus free, phase change end sequence at detection
// - reset before nexus in selection response: report 01H/00H
// - reset in selection transfer: 01H with step 81H, 82H, 92H, 93H, B1H or B2H
// - parity error in message-out after selection: end, report 24H/81H
// - parity error receiving command after identify: report 24H/92H
// - parity error in command phase without identify: 24H/B1H, auto mode or not
// - reset in message-in after command without identify: step B2H
// - handshake timeout in message-out after selection: end, report 2CH/81H
// - timeout receiving message after identify: report 2CH/82H
// - timeout receiving command after identify: report 2CH/92H
// - timeout in message-in after identify and command: report 2CH/93H

module sars_status (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic auto_mode,
   input wire logic arb_lost_wait,
   input wire logic host_cmd,
   input wire logic op_done,
   input wire logic reselected,
   input wire logic selected,
   input wire logic enter_msgout,
   input wire logic identify_done,
   input wire logic enter_cmd,
   input wire logic cmd_done,
   input wire logic enter_msgin,
   input wire logic enter_other,
   input wire logic msg_byte,
   input wire logic [7:0] msg_data,
   input wire logic msg_done,
   input wire logic rx_buf_busy,
   input wire logic req_ack_timeout,
   input wire sars_pkg::sars_cond_s bus_cond,
   input wire logic host_ack,
   output logic irq_pending,
   output logic [7:0] irq_code,
   output logic [7:0] irq_step,
   output logic seq_end
);

   // ==========================================================
   // pin synchronisers
   sars_pkg::sars_cond_s cond_meta_reg;
   sars_pkg::sars_cond_s cond_reg;
   logic reset_prev_reg;
   logic reset_edge;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cond_meta_reg <= '0;
         cond_reg <= '0;
         reset_prev_reg <= 1'b0;
      end else begin
         cond_meta_reg <= bus_cond;
         cond_reg <= cond_meta_reg;
         reset_prev_reg <= cond_reg.bus_reset;
      end
   end

   // a held reset level reports once, not every idle cycle
   assign reset_edge = cond_reg.bus_reset && !reset_prev_reg;

   // ==========================================================
   // step code for the current selection stage
   function automatic logic [7:0] sel_step(input sars_pkg::sars_seq_e s);
      case (s)
         sars_pkg::SARS_S_MSGOUT: sel_step = `SARS_STEP_MSGOUT;
         sars_pkg::SARS_S_ID_MSG: sel_step = `SARS_STEP_ID_MSG;
         sars_pkg::SARS_S_ID_CMD: sel_step = `SARS_STEP_ID_CMD;
         sars_pkg::SARS_S_ID_CMD_MI: sel_step = `SARS_STEP_ID_CMD_MI;
         sars_pkg::SARS_S_CMD: sel_step = `SARS_STEP_CMD;
         sars_pkg::SARS_S_CMD_MI: sel_step = `SARS_STEP_CMD_MI;
         default: sel_step = `SARS_STEP_NONE;
      endcase
   endfunction : sel_step

   function automatic logic in_sel_xfer(input sars_pkg::sars_seq_e s);
      in_sel_xfer = (sel_step(s) != `SARS_STEP_NONE);
   endfunction : in_sel_xfer

   // ==========================================================
   // state
   sars_pkg::sars_state_s st_reg;
   sars_pkg::sars_state_s st_next;
   logic end_next;
   logic end_reg;

   always_comb begin
      logic rep_v;
      logic [7:0] rc;
      logic [7:0] rs;
      rep_v = 1'b0;
      rc = `SARS_STEP_NONE;
      rs = `SARS_STEP_NONE;
      st_next = st_reg;
      end_next = 1'b0;
      if (host_ack) begin
         st_next.pending = 1'b0;
      end
      if (arb_lost_wait && reselected) begin
         st_next.double_after = 1'b1;
      end
      if (host_cmd && st_reg.seq != sars_pkg::SARS_IDLE) begin
         st_next.defer_double = 1'b1;
      end
      case (st_reg.seq)
         sars_pkg::SARS_IDLE: begin
            if (reset_edge) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_RESET;
            end else if (reselected) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_RESEL;
               if (arb_lost_wait) begin
                  rc = `SARS_CODE_DOUBLE;
               end
               st_next.seq = sars_pkg::SARS_R_NEXUS;
            end else if (selected) begin
               st_next.seq = sars_pkg::SARS_S_NEXUS;
            end
         end
         sars_pkg::SARS_R_NEXUS: begin
            if (st_reg.double_after && !st_reg.pending) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_RESEL;
               st_next.double_after = 1'b0;
            end else if (cond_reg.bus_reset) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_RESET;
               end_next = 1'b1;
               st_next.seq = sars_pkg::SARS_IDLE;
            end else if (cond_reg.bus_free) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_FREE_NEXUS;
               end_next = 1'b1;
               st_next.seq = sars_pkg::SARS_IDLE;
            end else if (enter_other) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_OTHERPH;
               rs = `SARS_STEP_RMSGIN;
               st_next.seq = sars_pkg::SARS_IDLE;
            end else if (enter_msgin && auto_mode) begin
               if (rx_buf_busy) begin
                  rep_v = 1'b1;
                  rc = `SARS_CODE_BUFBUSY;
                  st_next.seq = sars_pkg::SARS_IDLE;
               end else begin
                  st_next.seq = sars_pkg::SARS_R_MSGIN;
                  st_next.ext_len = '0;
                  st_next.ext_second = 1'b0;
               end
            end
         end
         sars_pkg::SARS_R_MSGIN: begin
            rs = `SARS_STEP_RMSGIN;
            if (cond_reg.bus_reset || cond_reg.parity_err || cond_reg.bus_free
               || cond_reg.phase_chg || req_ack_timeout) begin
               rep_v = 1'b1;
               end_next = 1'b1;
               st_next.seq = sars_pkg::SARS_IDLE;
               if (cond_reg.bus_reset) begin
                  rc = `SARS_CODE_RESET;
               end else if (cond_reg.parity_err) begin
                  rc = `SARS_CODE_PARITY;
               end else if (req_ack_timeout) begin
                  rc = `SARS_CODE_TIMEOUT;
               end else if (cond_reg.bus_free) begin
                  rc = `SARS_CODE_BUSFREE;
               end else begin
                  rc = `SARS_CODE_PHASECHG;
               end
            end else if (msg_byte && st_reg.ext_second) begin
               st_next.ext_second = 1'b0;
               if (msg_data >= `SARS_EXT_LIMIT) begin
                  rep_v = 1'b1;
                  rc = `SARS_CODE_LONGMSG;
                  end_next = 1'b1;
                  st_next.seq = sars_pkg::SARS_IDLE;
               end
            end else if (msg_byte && st_reg.ext_len == '0) begin
               st_next.ext_len = 8'h01;
               st_next.ext_second = (msg_data == 8'h01);
            end else if (msg_done) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_MSGOK;
               rs = `SARS_STEP_RDONE;
               st_next.seq = sars_pkg::SARS_IDLE;
            end
         end
         default: begin
            if (in_sel_xfer(st_reg.seq) && (cond_reg.bus_reset || cond_reg.parity_err
               || req_ack_timeout)) begin
               rep_v = 1'b1;
               end_next = 1'b1;
               rs = sel_step(st_reg.seq);
               st_next.seq = sars_pkg::SARS_IDLE;
               if (cond_reg.bus_reset) begin
                  rc = `SARS_CODE_RESET;
               end else if (cond_reg.parity_err) begin
                  rc = `SARS_CODE_PARITY;
               end else begin
                  rc = `SARS_CODE_TIMEOUT;
               end
            end else if (st_reg.seq == sars_pkg::SARS_S_NEXUS && cond_reg.bus_reset) begin
               rep_v = 1'b1;
               rc = `SARS_CODE_RESET;
               end_next = 1'b1;
               st_next.seq = sars_pkg::SARS_IDLE;
            end else if (cond_reg.bus_free || op_done) begin
               st_next.seq = sars_pkg::SARS_IDLE;
            end else if (st_reg.seq == sars_pkg::SARS_S_NEXUS) begin
               if (enter_msgout && auto_mode) begin
                  st_next.seq = sars_pkg::SARS_S_MSGOUT;
               end else if (enter_cmd) begin
                  st_next.seq = sars_pkg::SARS_S_CMD;
               end
            end else if (st_reg.seq == sars_pkg::SARS_S_MSGOUT && identify_done) begin
               st_next.seq = enter_cmd ? sars_pkg::SARS_S_ID_CMD : sars_pkg::SARS_S_ID_MSG;
            end else if (st_reg.seq == sars_pkg::SARS_S_ID_MSG && enter_cmd) begin
               st_next.seq = sars_pkg::SARS_S_ID_CMD;
            end else if (st_reg.seq == sars_pkg::SARS_S_ID_CMD && cmd_done && enter_msgin) begin
               st_next.seq = sars_pkg::SARS_S_ID_CMD_MI;
            end else if (st_reg.seq == sars_pkg::SARS_S_CMD && cmd_done && enter_msgin) begin
               st_next.seq = sars_pkg::SARS_S_CMD_MI;
            end
         end
      endcase
      if (op_done && st_reg.defer_double && !rep_v && !st_reg.pending) begin
         rep_v = 1'b1;
         rc = `SARS_CODE_DOUBLE;
         rs = `SARS_STEP_NONE;
         st_next.defer_double = 1'b0;
      end
      if (rep_v) begin
         st_next.rep.code = rc;
         st_next.rep.step = rs;
         st_next.pending = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         st_reg <= '{seq: sars_pkg::SARS_IDLE, default: '0};
         end_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         end_reg <= end_next;
      end
   end

   assign irq_pending = st_reg.pending;
   assign irq_code = st_reg.rep.code;
   assign irq_step = st_reg.rep.step;
   assign seq_end = end_reg;

   // ==========================================================
   // checks
   sequence s_sel_reset;
      in_sel_xfer(st_reg.seq) && cond_reg.bus_reset;
   endsequence

   chk_resel_report: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_IDLE && !cond_reg.bus_reset && reselected && !arb_lost_wait
      |=> irq_code == `SARS_CODE_RESEL && irq_step == `SARS_STEP_NONE)
      else $error("reselection not reported");
   chk_sel_reset_step: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_sel_reset |=> irq_code == `SARS_CODE_RESET && seq_end
      && irq_step == sel_step($past(st_reg.seq)))
      else $error("selection reset step wrong");
   chk_end_immediate: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_R_MSGIN && cond_reg.phase_chg && !cond_reg.bus_reset
      && !cond_reg.parity_err && !cond_reg.bus_free && !req_ack_timeout
      |=> seq_end && irq_code == `SARS_CODE_PHASECHG && st_reg.seq == sars_pkg::SARS_IDLE)
      else $error("phase change not ended");
   chk_buf_busy: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_R_NEXUS && !st_reg.double_after && !cond_reg.bus_reset
      && !cond_reg.bus_free && !enter_other && enter_msgin && auto_mode && rx_buf_busy
      |=> irq_code == `SARS_CODE_BUFBUSY && st_reg.seq != sars_pkg::SARS_R_MSGIN)
      else $error("busy buffer message taken");
   chk_report_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
      irq_pending && !host_ack |=> irq_pending && $stable(irq_code) && $stable(irq_step))
      else $error("report changed before ack");
   chk_nexus_free: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_R_NEXUS && !st_reg.double_after && !cond_reg.bus_reset
      && cond_reg.bus_free |=> irq_code == `SARS_CODE_FREE_NEXUS ##1 !seq_end)
      else $error("bus free at nexus not reported");
   chk_other_phase: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_R_NEXUS && !st_reg.double_after && !cond_reg.bus_reset
      && !cond_reg.bus_free && enter_other
      |=> irq_code == `SARS_CODE_OTHERPH && irq_step == `SARS_STEP_RMSGIN)
      else $error("other phase not reported");
   chk_msg_ok: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_R_MSGIN && !cond_reg.bus_reset && !cond_reg.parity_err
      && !cond_reg.bus_free && !cond_reg.phase_chg && !req_ack_timeout && !msg_byte && msg_done
      |=> irq_code == `SARS_CODE_MSGOK && irq_step == `SARS_STEP_RDONE)
      else $error("message success not reported");

   sequence s_msgin_quiet;
      st_reg.seq == sars_pkg::SARS_R_MSGIN && !cond_reg.bus_reset && !cond_reg.parity_err
      && !cond_reg.bus_free && !cond_reg.phase_chg && !req_ack_timeout;
   endsequence

   chk_long_msg: assert property (@(posedge ref_clk) disable iff (!rstn)
      s_msgin_quiet ##0 (msg_byte && st_reg.ext_second && msg_data >= `SARS_EXT_LIMIT)
      |=> irq_code == `SARS_CODE_LONGMSG && irq_step == `SARS_STEP_RMSGIN && seq_end)
      else $error("long message not ended");
   chk_idle_reset: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_IDLE && reset_edge
      |=> irq_code == `SARS_CODE_RESET && irq_step == `SARS_STEP_NONE && irq_pending)
      else $error("reset before nexus not reported");
   chk_sel_parity: assert property (@(posedge ref_clk) disable iff (!rstn)
      in_sel_xfer(st_reg.seq) && !cond_reg.bus_reset && cond_reg.parity_err
      |=> irq_code == `SARS_CODE_PARITY && seq_end && irq_step == sel_step($past(st_reg.seq)))
      else $error("selection parity error not reported");
   chk_sel_timeout: assert property (@(posedge ref_clk) disable iff (!rstn)
      in_sel_xfer(st_reg.seq) && !cond_reg.bus_reset && !cond_reg.parity_err && req_ack_timeout
      |=> irq_code == `SARS_CODE_TIMEOUT && seq_end && irq_step == sel_step($past(st_reg.seq)))
      else $error("selection timeout not reported");
   chk_double_first: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_IDLE && !reset_edge && reselected && arb_lost_wait
      |=> irq_code == `SARS_CODE_DOUBLE && irq_step == `SARS_STEP_NONE && st_reg.double_after)
      else $error("lost arbitration not reported first");
   chk_double_then: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_R_NEXUS && st_reg.double_after && !st_reg.pending
      |=> irq_code == `SARS_CODE_RESEL && irq_pending && !st_reg.double_after)
      else $error("reselection not reported second");
   chk_defer_double: assert property (@(posedge ref_clk) disable iff (!rstn)
      st_reg.seq == sars_pkg::SARS_IDLE && !reset_edge && !reselected && !selected && op_done
      && st_reg.defer_double && !st_reg.pending |=> irq_code == `SARS_CODE_DOUBLE)
      else $error("deferred double command not reported");
endmodule : sars_status

// ---- rtl/sars_defines.svh ----
`ifndef SARS_DEFINES_SVH
`define SARS_DEFINES_SVH
// interrupt codes
`define SARS_CODE_RESET 8'h01
`define SARS_CODE_PARITY 8'h24
`define SARS_CODE_TIMEOUT 8'h2C
`define SARS_CODE_BUSFREE 8'h31
`define SARS_CODE_PHASECHG 8'h32
`define SARS_CODE_DOUBLE 8'h64
`define SARS_CODE_LONGMSG 8'h67
`define SARS_CODE_FREE_NEXUS 8'h70
`define SARS_CODE_RESEL 8'h90
`define SARS_CODE_BUFBUSY 8'h94
`define SARS_CODE_OTHERPH 8'hB0
`define SARS_CODE_MSGOK 8'hB1
// step codes
`define SARS_STEP_NONE 8'h00
`define SARS_STEP_RMSGIN 8'h01
`define SARS_STEP_RDONE 8'h02
`define SARS_STEP_MSGOUT 8'h81
`define SARS_STEP_ID_MSG 8'h82
`define SARS_STEP_ID_CMD 8'h92
`define SARS_STEP_ID_CMD_MI 8'h93
`define SARS_STEP_CMD 8'hB1
`define SARS_STEP_CMD_MI 8'hB2
// extended message limit in bytes
`define SARS_EXT_LIMIT 8'h21
`endif

// ---- rtl/sars_pkg.sv ----
package sars_pkg;
   // automatic sequence position
   typedef enum logic [3:0] {
      SARS_IDLE = 4'h0,
      SARS_R_NEXUS = 4'h1,
      SARS_R_MSGIN = 4'h3,
      SARS_S_NEXUS = 4'h2,
      SARS_S_MSGOUT = 4'h6,
      SARS_S_ID_MSG = 4'h7,
      SARS_S_ID_CMD = 4'h5,
      SARS_S_ID_CMD_MI = 4'h4,
      SARS_S_CMD = 4'hC,
      SARS_S_CMD_MI = 4'hD
   } sars_seq_e;

   // synchronised bus conditions
   typedef struct packed {
      logic bus_reset;
      logic parity_err;
      logic bus_free;
      logic phase_chg;
   } sars_cond_s;

   typedef struct packed {
      logic [7:0] code;
      logic [7:0] step;
   } sars_report_s;

   typedef struct packed {
      sars_seq_e seq;
      logic [7:0] ext_len;
      logic ext_second;
      logic defer_double;
      logic double_after;
      logic pending;
      sars_report_s rep;
   } sars_state_s;
endpackage : sars_pkg

// ---- verification/sars_far_end.sv ----
`timescale 1ns/1ps
// ==========================================
// far bus party: phase pulses, message bytes, bus conditions
module sars_far_end (
   input wire logic ref_clk,
   output logic [10:0] ph,
   output logic [7:0] msg_data,
   output sars_pkg::sars_cond_s bus_cond
);
   // ph: 0 resel 1 sel 2 msgout 3 ident 4 cmd 5 cmd_done 6 msgin 7 other
   // 8 msg_done 9 timeout 10 msg_byte
   initial begin
      ph = '0;
      msg_data = 8'hA5;
      bus_cond = '0;
   end

   // one-cycle pulse after a prompt or slow wait
   task automatic fire(input int b, input int dly);
      repeat (dly) @(negedge ref_clk);
      ph[b] = 1'b1;
      @(negedge ref_clk);
      ph[b] = 1'b0;
   endtask : fire

   // two phase pulses in the same cycle
   task automatic fire2(input int a, input int b);
      ph = ph | (11'h001 << a) | (11'h001 << b);
      @(negedge ref_clk);
      ph = 11'h000;
   endtask : fire2

   // data valid for one cycle only, then the line shows the inverse
   task automatic send_byte(input logic [7:0] d);
      msg_data = d;
      ph[10] = 1'b1;
      @(negedge ref_clk);
      ph[10] = 1'b0;
      msg_data = ~d;
   endtask : send_byte

   // asynchronous level held long enough for the synchroniser
   task automatic cond(input int b, input int len);
      bus_cond[b] = 1'b1;
      repeat (len) @(negedge ref_clk);
      bus_cond = '0;
   endtask : cond
endmodule : sars_far_end

// ---- verification/scsi_auto_select_status_codes_test.sv ----
`timescale 1ns/1ps
module scsi_auto_select_status_codes_test;
   logic ref_clk, rstn, auto_mode, arb_lost_wait, host_cmd, op_done, rx_buf_busy, host_ack;
   logic [10:0] ph;
   logic [7:0] msg_data;
   sars_pkg::sars_cond_s bus_cond;
   logic irq_pending, seq_end, end_seen;
   logic [7:0] irq_code, irq_step;
   logic [31:0] rnd;
   logic [15:0] exp_q[$];
   int error_cnt, n_tests, cyc, st, ty, d;

   sars_far_end u_far (.ref_clk(ref_clk), .ph(ph), .msg_data(msg_data), .bus_cond(bus_cond));
   sars_status u_dut (.ref_clk(ref_clk), .rstn(rstn), .auto_mode(auto_mode),
      .arb_lost_wait(arb_lost_wait), .host_cmd(host_cmd), .op_done(op_done),
      .reselected(ph[0]), .selected(ph[1]), .enter_msgout(ph[2]), .identify_done(ph[3]),
      .enter_cmd(ph[4]), .cmd_done(ph[5]), .enter_msgin(ph[6]), .enter_other(ph[7]),
      .msg_byte(ph[10]), .msg_data(msg_data), .msg_done(ph[8]), .rx_buf_busy(rx_buf_busy),
      .req_ack_timeout(ph[9]), .bus_cond(bus_cond), .host_ack(host_ack),
      .irq_pending(irq_pending), .irq_code(irq_code), .irq_step(irq_step), .seq_end(seq_end));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         wrap_up();
      end
   end

   // end pulse sampled where it is settled
   always @(negedge ref_clk) begin
      if (seq_end === 1'b1) end_seen = 1'b1;
   end

   function automatic logic [31:0] next_rnd();
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      return rnd;
   endfunction : next_rnd

   // ==========================================
   // reference model: sequence position and expected reports
   function automatic void push(input logic [7:0] c, input logic [7:0] s, input int n);
      exp_q.push_back({c, s});
      st = n;
   endfunction : push

   function automatic void mdl(input int ev);
      logic [7:0] stp [10];
      stp = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h81, 8'h82, 8'h92, 8'h93, 8'hB1, 8'hB2};
      if (ev == 0) push(8'h90, 8'h00, 1);
      else if (ev == 12 && st == 0) push(8'h01, 8'h00, 0);
      else if (st == 1 && ev == 6) begin
         if (rx_buf_busy) push(8'h94, 8'h00, 0);
         else st = 2;
      end
      else if (st == 1 && ev == 7) push(8'hB0, 8'h01, 0);
      else if (st == 1 && ev == 13) push(8'h70, 8'h00, 0);
      else if (st == 2 && ev == 8) push(8'hB1, 8'h02, 0);
      else if (st == 2 && ev == 14) push(8'h32, 8'h01, 0);
      else if (st == 2 && ev == 15) push(8'h67, 8'h01, 0);
      else if (ev == 1) st = 3;
      else if (st == 3 && ev == 2) st = 4;
      else if (st == 4 && ev == 3) st = 5;
      else if (st == 5 && ev == 4) st = 6;
      else if (st == 6 && ev == 6) st = 7;
      else if (st == 3 && ev == 4) st = 8;
      else if (st == 8 && ev == 6) st = 9;
      else if (st >= 4 && (ev == 9 || ev == 11 || ev == 12))
         push(ev == 12 ? 8'h01 : ev == 11 ? 8'h24 : 8'h2C, stp[st], 0);
   endfunction : mdl

   // ==========================================
   // drivers and comparisons
   task automatic go(input int e);
      mdl(e);
      if (e <= 9) u_far.fire(e, int'(next_rnd() % 3));
      else u_far.cond(e == 11 ? 2 : e == 12 ? 3 : e == 13 ? 1 : 0, 4);
   endtask : go

   task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_byte

   task automatic cmp_bit(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp_bit

   task automatic chk_rep();
      logic [15:0] e;
      e = exp_q.pop_front();
      for (int i = 0; i < 8 && {irq_code, irq_step} !== e; i++) @(negedge ref_clk);
      cmp_byte("irq_code", e[15:8], irq_code);
      cmp_byte("irq_step", e[7:0], irq_step);
      cmp_bit("irq_pending", 1'b1, irq_pending);
   endtask : chk_rep

   task automatic ack();
      host_ack = 1'b1;
      @(negedge ref_clk);
      host_ack = 1'b0;
      // looked at before a queued report may set it again
      cmp_bit("irq_pending", 1'b0, irq_pending);
      @(negedge ref_clk);
   endtask : ack

   task automatic do_reset();
      rstn = 1'b0;
      auto_mode = 1'b1;
      arb_lost_wait = 1'b0;
      rx_buf_busy = 1'b0;
      repeat (2) @(negedge ref_clk);
      rstn = 1'b1;
      st = 0;
      end_seen = 1'b0;
      exp_q.delete();
   endtask : do_reset

   task automatic resel_ack();
      do_reset();
      go(0);
      chk_rep();
      ack();
   endtask : resel_ack

   task automatic wrap_up();
      $display("comparisons %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // ==========================================
   // scenarios
   initial begin
      rstn = 1'b0;
      {auto_mode, arb_lost_wait, host_cmd, op_done, rx_buf_busy, host_ack} = '0;
      rnd = 32'h0000786C;
      resel_ack();
      go(6);
      host_cmd = 1'b1;
      @(negedge ref_clk);
      host_cmd = 1'b0;
      go(8);
      chk_rep();
      cmp_byte("held_code", 8'hB1, irq_code);
      ack();
      op_done = 1'b1;
      @(negedge ref_clk);
      op_done = 1'b0;
      exp_q.push_back(16'h6400);
      chk_rep();
      resel_ack();
      rx_buf_busy = 1'b1;
      go(6);
      chk_rep();
      resel_ack();
      go(7);
      chk_rep();
      resel_ack();
      go(13);
      chk_rep();
      resel_ack();
      go(6);
      go(14);
      chk_rep();
      @(negedge ref_clk);
      cmp_bit("seq_end", 1'b1, end_seen);
      resel_ack();
      go(6);
      u_far.send_byte(8'h01);
      u_far.send_byte(8'h20);
      go(8);
      chk_rep();
      resel_ack();
      go(6);
      u_far.send_byte(8'h01);
      mdl(15);
      u_far.send_byte(8'h21 + 8'(next_rnd() % 223));
      chk_rep();
      do_reset();
      go(12);
      chk_rep();
      do_reset();
      auto_mode = 1'b0;
      go(0);
      chk_rep();
      do_reset();
      arb_lost_wait = 1'b1;
      exp_q.push_back(16'h6400);
      go(0);
      chk_rep();
      arb_lost_wait = 1'b0;
      ack();
      chk_rep();
      for (ty = 9; ty <= 12; ty++) begin
         if (ty == 10) continue;
         for (d = 4; d <= 9; d++) begin
            do_reset();
            go(1);
            if (d >= 8) go(4);
            else go(2);
            if (d > 4 && d < 8) go(3);
            if (d > 5 && d < 8) go(4);
            if (d == 7 || d == 9) begin
               mdl(6);
               u_far.fire2(5, 6);
            end
            go(ty);
            chk_rep();
            @(negedge ref_clk);
            cmp_bit("seq_end", 1'b1, end_seen);
         end
      end
      wrap_up();
   end
endmodule : scsi_auto_select_status_codes_test
